// ---- hdl/l2cap_top.sv ----
// Cache command access port: Wishbone registers and cache command driver
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module l2cap_top #(
	parameter int AW = 12
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [AW-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic l2_req_valid_o,
	output l2cap_pkg::l2cap_req_t l2_req_o,
	input wire logic l2_done_i,
	input wire l2cap_pkg::l2cap_rsp_t l2_rsp_i,
	input wire logic [2:0] cfg_addr_range_i,
	input wire logic cfg_hw_disable_i,
	input wire logic cfg_bus_fraction_i,
	output logic state_check_en_o
);
	if (AW < l2cap_pkg::IDX_W + 2) begin : g_aw_check
		$error("AW too small for the register map");
	end

	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0] sel
	);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return res;
	endfunction

	logic ack;
	logic [31:0] rd_data;
	logic [l2cap_pkg::IDX_W-1:0] idx;
	logic upper_zero;
	logic bus_req;
	logic wr_take;
	logic wr_addr;
	logic wr_ecc;
	logic wr_ctrl;
	logic wr_chunk_lo;
	logic wr_chunk_hi;
	logic wr_cfg;
	logic trig_zero;
	logic launch;

	logic [l2cap_pkg::ADDR_MSB:l2cap_pkg::ADDR_LSB] addr;
	logic [7:0] ecc;
	logic [31:0] chunk_lo;
	logic [31:0] chunk_hi;
	logic [4:0] cmd;
	logic [1:0] way_to;
	logic [1:0] state_to;
	logic [1:0] uecc_sel;
	logic proc_sel;
	logic hit;
	logic [1:0] state_from;
	logic [1:0] way_from;
	logic chk_en;
	logic [4:0] run_cmd;
	logic [31:0] next_rd_data;
	logic [31:0] ctrl_word;
	logic [31:0] cfg_word;
	logic [31:0] addr_merged;
	logic [31:0] ecc_merged;
	logic [31:0] ctrl_merged;
	logic [31:0] chunk_lo_merged;
	logic [31:0] chunk_hi_merged;
	logic [31:0] cfg_merged;
	l2cap_pkg::l2cap_op_t dec_op;
	l2cap_pkg::l2cap_op_t run_op;
	logic seq_req;
	logic seq_busy;
	logic seq_done;
	logic rsp_has_data;

	// Field widths of the register words
	localparam int BYTE_OFS_W = 2;
	localparam int WORD_W = 32;
	localparam int ST_W = $bits(l2cap_pkg::l2cap_line_state_t);
	localparam int WAY_W = $bits(l2cap_pkg::l2cap_way_t);
	localparam int UECC_W = 2;
	localparam int RANGE_W = 3;

	// Commands whose answer carries check bits and line data
	function automatic logic returns_data(input l2cap_pkg::l2cap_op_t op);
		logic res;
		res = 1'b0;
		case (op)
			l2cap_pkg::L2CAP_OP_DATA_READ_LRU_TOUCH: res = 1'b1;
			l2cap_pkg::L2CAP_OP_TAG_AND_DATA_READ: res = 1'b1;
			l2cap_pkg::L2CAP_OP_TAG_WRITE_DATA_READ: res = 1'b1;
			l2cap_pkg::L2CAP_OP_CTRL_REG_READ: res = 1'b1;
			default: res = 1'b0;
		endcase
		return res;
	endfunction

	// Bus decode: byte address, one register per word index
	assign upper_zero = ((wb_adr_i >> (l2cap_pkg::IDX_W + BYTE_OFS_W)) == '0);
	assign idx = wb_adr_i[BYTE_OFS_W +: l2cap_pkg::IDX_W];
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign wr_take = ce_i && bus_req && wb_we_i && ack && upper_zero;
	assign wr_addr = wr_take && (idx == l2cap_pkg::IDX_ADDR);
	assign wr_ecc = wr_take && (idx == l2cap_pkg::IDX_ECC);
	assign wr_ctrl = wr_take && (idx == l2cap_pkg::IDX_CTRL);
	assign wr_chunk_lo = wr_take && (idx == l2cap_pkg::IDX_CHUNK3);
	assign wr_chunk_hi = wr_take && (idx == l2cap_pkg::IDX_CHUNK3_HI);
	assign wr_cfg = wr_take && (idx == l2cap_pkg::IDX_CFG);
	assign trig_zero = (wb_dat_i == l2cap_pkg::TRIG_LAUNCH);
	assign launch = wr_take && (idx == l2cap_pkg::IDX_TRIG) && trig_zero && !seq_busy;

	assign addr_merged = merge_bytes({addr, {l2cap_pkg::ADDR_LSB{1'b0}}}, wb_dat_i, wb_sel_i);
	assign ecc_merged = merge_bytes({{(WORD_W - l2cap_pkg::ECC_W){1'b0}}, ecc}, wb_dat_i,
		wb_sel_i);
	assign ctrl_merged = merge_bytes(ctrl_word, wb_dat_i, wb_sel_i);
	assign chunk_lo_merged = merge_bytes(chunk_lo, wb_dat_i, wb_sel_i);
	assign chunk_hi_merged = merge_bytes(chunk_hi, wb_dat_i, wb_sel_i);
	assign cfg_merged = merge_bytes(cfg_word, wb_dat_i, wb_sel_i);

	// One wait state: ack rises one cycle after the request and drops after one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else if (ce_i) begin
			ack <= bus_req && !ack;
		end
	end
	assign wb_ack_o = ack;

	// Read data is registered in the cycle that raises ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data <= l2cap_pkg::RST_WORD;
		end else if (ce_i && bus_req && !ack) begin
			rd_data <= next_rd_data;
		end
	end
	assign wb_dat_o = rd_data;

	always_comb begin
		ctrl_word = l2cap_pkg::RST_WORD;
		ctrl_word[l2cap_pkg::CTL_CMD_LSB +: l2cap_pkg::CMD_W] = cmd;
		ctrl_word[l2cap_pkg::CTL_STATE_TO_LSB +: ST_W] = state_to;
		ctrl_word[l2cap_pkg::CTL_WAY_TO_LSB +: WAY_W] = way_to;
		ctrl_word[l2cap_pkg::CTL_WAY_FROM_LSB +: WAY_W] = way_from;
		ctrl_word[l2cap_pkg::CTL_STATE_FROM_LSB +: ST_W] = state_from;
		ctrl_word[l2cap_pkg::CTL_HIT_BIT] = hit;
		ctrl_word[l2cap_pkg::CTL_UECC_LSB +: UECC_W] = uecc_sel;
		ctrl_word[l2cap_pkg::CTL_PROC_BIT] = proc_sel;
	end

	always_comb begin
		cfg_word = l2cap_pkg::RST_WORD;
		cfg_word[l2cap_pkg::CFG_CHK_BIT] = chk_en;
		cfg_word[l2cap_pkg::CFG_RANGE_LSB +: RANGE_W] = cfg_addr_range_i;
		cfg_word[l2cap_pkg::CFG_HWDIS_BIT] = cfg_hw_disable_i;
		cfg_word[l2cap_pkg::CFG_FRAC_BIT] = cfg_bus_fraction_i;
	end

	// Read mux; the trigger register and unused indices read zero
	always_comb begin
		next_rd_data = l2cap_pkg::RST_WORD;
		if (upper_zero) begin
			case (idx)
				l2cap_pkg::IDX_CHUNK3: begin
					next_rd_data = chunk_lo;
				end
				l2cap_pkg::IDX_CHUNK3_HI: begin
					next_rd_data = chunk_hi;
				end
				l2cap_pkg::IDX_ADDR: begin
					next_rd_data = {addr, {l2cap_pkg::ADDR_LSB{1'b0}}};
				end
				l2cap_pkg::IDX_ECC: begin
					next_rd_data = {{(WORD_W - l2cap_pkg::ECC_W){1'b0}}, ecc};
				end
				l2cap_pkg::IDX_CTRL: begin
					next_rd_data = ctrl_word;
				end
				l2cap_pkg::IDX_BUSY: begin
					next_rd_data[l2cap_pkg::BUSY_BIT] = seq_busy;
				end
				l2cap_pkg::IDX_CFG: begin
					next_rd_data = cfg_word;
				end
				default: begin
					next_rd_data = l2cap_pkg::RST_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr <= l2cap_pkg::RST_WORD[l2cap_pkg::ADDR_MSB:l2cap_pkg::ADDR_LSB];
		end else if (wr_addr) begin
			addr <= addr_merged[l2cap_pkg::ADDR_MSB:l2cap_pkg::ADDR_LSB];
		end
	end

	// A returned check value wins over a software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ecc <= l2cap_pkg::RST_WORD[l2cap_pkg::ECC_W-1:0];
		end else if (ce_i && seq_done && rsp_has_data) begin
			ecc <= l2_rsp_i.ecc;
		end else if (wr_ecc) begin
			ecc <= ecc_merged[l2cap_pkg::ECC_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd <= l2cap_pkg::RST_WORD[l2cap_pkg::CMD_W-1:0];
		end else if (wr_ctrl) begin
			cmd <= ctrl_merged[l2cap_pkg::CTL_CMD_LSB +: l2cap_pkg::CMD_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			way_to <= l2cap_pkg::RST_WORD[WAY_W-1:0];
		end else if (wr_ctrl) begin
			way_to <= ctrl_merged[l2cap_pkg::CTL_WAY_TO_LSB +: WAY_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_to <= l2cap_pkg::RST_WORD[ST_W-1:0];
		end else if (wr_ctrl) begin
			state_to <= ctrl_merged[l2cap_pkg::CTL_STATE_TO_LSB +: ST_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			uecc_sel <= l2cap_pkg::RST_WORD[UECC_W-1:0];
			proc_sel <= 1'b0;
		end else if (wr_ctrl) begin
			uecc_sel <= ctrl_merged[l2cap_pkg::CTL_UECC_LSB +: UECC_W];
			proc_sel <= ctrl_merged[l2cap_pkg::CTL_PROC_BIT];
		end
	end

	// Lookup response is captured only in the cycle the cache reports done
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hit <= 1'b0;
			state_from <= l2cap_pkg::RST_WORD[ST_W-1:0];
			way_from <= l2cap_pkg::RST_WORD[WAY_W-1:0];
		end else if (ce_i && seq_done) begin
			hit <= l2_rsp_i.hit;
			state_from <= l2_rsp_i.state;
			way_from <= l2_rsp_i.way;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chunk_lo <= l2cap_pkg::RST_WORD;
		end else if (ce_i && seq_done && rsp_has_data) begin
			chunk_lo <= l2_rsp_i.data[WORD_W-1:0];
		end else if (wr_chunk_lo) begin
			chunk_lo <= chunk_lo_merged;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chunk_hi <= l2cap_pkg::RST_WORD;
		end else if (ce_i && seq_done && rsp_has_data) begin
			chunk_hi <= l2_rsp_i.data[2*WORD_W-1:WORD_W];
		end else if (wr_chunk_hi) begin
			chunk_hi <= chunk_hi_merged;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chk_en <= 1'b0;
		end else if (wr_cfg) begin
			chk_en <= cfg_merged[l2cap_pkg::CFG_CHK_BIT];
		end
	end
	assign state_check_en_o = chk_en;

	// The command is frozen at launch so a later control write cannot alter it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_cmd <= l2cap_pkg::RST_WORD[l2cap_pkg::CMD_W-1:0];
		end else if (ce_i && launch) begin
			run_cmd <= cmd;
		end
	end

	assign dec_op = l2cap_pkg::l2cap_decode(cmd);
	assign rsp_has_data = returns_data(run_op);

	l2cap_cmd_seq u_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.launch_i(launch),
		.op_i(dec_op),
		.l2_done_i(l2_done_i),
		.l2_req_o(seq_req),
		.op_o(run_op),
		.busy_o(seq_busy),
		.done_o(seq_done)
	);

	assign l2_req_valid_o = seq_req;

	always_comb begin
		l2_req_o.cmd = run_cmd;
		l2_req_o.op = run_op;
		l2_req_o.addr = addr;
		l2_req_o.way = way_to;
		l2_req_o.state = l2cap_pkg::l2cap_line_state_t'(state_to);
		l2_req_o.ecc = ecc;
		l2_req_o.data = {chunk_hi, chunk_lo};
	end
endmodule

// ---- hdl/l2cap_pkg.sv ----
// Constants, types and decode function of the cache command access port
// What this block does
// - ECC register holds 8 check bits: sent on writes, loaded on reads.
// - Control register bits 4:0 hold the command run on trigger.
// - After lookup, control shows hit at bit 17, state and way.
// - Codes 01100 data read with LRU, 01110 tag+data read, 01111 inquire.
// - Code 00010 reads the cache control register, 00011 writes it.
// - Tag writes: prefix 010, 111 or 100 followed by 2-bit line state.
// - Line state coding: 11 modified, 10 exclusive, 01 shared, 00 invalid.
// - Writing zero to trigger register launches the programmed command.
// - Busy bit 0 reads 1 while a command runs, 0 when done.
// - Config bits 22:20 read-only physical address range, 111 down to 000.
// - Config bit 18 is read/write line state error check enable.
// - Config bit 23 read-only: cache disabled in hardware.
// - Config bit 25 read-only: cache bus clock fraction.
// - Index 8B is data chunk 3 or update signature register.
package l2cap_pkg;
	localparam int IDX_W = 9;
	localparam logic [8:0] IDX_CHUNK3 = 9'h08b;
	localparam logic [8:0] IDX_CHUNK3_HI = 9'h120;
	localparam logic [8:0] IDX_ADDR = 9'h116;
	localparam logic [8:0] IDX_ECC = 9'h118;
	localparam logic [8:0] IDX_CTRL = 9'h119;
	localparam logic [8:0] IDX_TRIG = 9'h11a;
	localparam logic [8:0] IDX_BUSY = 9'h11b;
	localparam logic [8:0] IDX_CFG = 9'h11e;
	localparam int ADDR_LSB = 3;
	localparam int ADDR_MSB = 31;
	localparam int ECC_W = 8;
	localparam int CMD_W = 5;
	localparam int CTL_CMD_LSB = 0;
	localparam int CTL_STATE_TO_LSB = 5;
	localparam int CTL_WAY_TO_LSB = 8;
	localparam int CTL_WAY_FROM_LSB = 10;
	localparam int CTL_STATE_FROM_LSB = 14;
	localparam int CTL_HIT_BIT = 17;
	localparam int CTL_UECC_LSB = 19;
	localparam int CTL_PROC_BIT = 21;
	localparam int BUSY_BIT = 0;
	localparam int CFG_CHK_BIT = 18;
	localparam int CFG_RANGE_LSB = 20;
	localparam int CFG_HWDIS_BIT = 23;
	localparam int CFG_FRAC_BIT = 25;
	localparam logic [4:0] CMD_DATA_READ_LRU_TOUCH = 5'h0c;
	localparam logic [4:0] CMD_TAG_AND_DATA_READ = 5'h0e;
	localparam logic [4:0] CMD_TAG_INQUIRE = 5'h0f;
	localparam logic [4:0] CMD_CTRL_REG_READ = 5'h02;
	localparam logic [4:0] CMD_CTRL_REG_WRITE = 5'h03;
	localparam logic [2:0] PFX_TAG_WRITE_DATA_READ = 3'h2;
	localparam logic [2:0] PFX_TAG_AND_DATA_WRITE = 3'h7;
	localparam logic [2:0] PFX_TAG_WRITE_ONLY = 3'h4;
	localparam logic [31:0] TRIG_LAUNCH = 32'h0;
	localparam logic [31:0] RST_WORD = 32'h0;
	typedef enum logic [1:0] {
		L2CAP_ST_INVALID = 2'h0,
		L2CAP_ST_SHARED = 2'h1,
		L2CAP_ST_EXCLUSIVE = 2'h2,
		L2CAP_ST_MODIFIED = 2'h3
	} l2cap_line_state_t;
	typedef logic [1:0] l2cap_way_t;
	typedef enum logic [8:0] {
		L2CAP_OP_NONE = 9'h001,
		L2CAP_OP_DATA_READ_LRU_TOUCH = 9'h002,
		L2CAP_OP_TAG_AND_DATA_READ = 9'h004,
		L2CAP_OP_TAG_INQUIRE = 9'h008,
		L2CAP_OP_CTRL_REG_READ = 9'h010,
		L2CAP_OP_CTRL_REG_WRITE = 9'h020,
		L2CAP_OP_TAG_WRITE_DATA_READ = 9'h040,
		L2CAP_OP_TAG_AND_DATA_WRITE = 9'h080,
		L2CAP_OP_TAG_WRITE_ONLY = 9'h100
	} l2cap_op_t;
	typedef struct packed {
		logic [4:0] cmd;
		l2cap_op_t op;
		logic [ADDR_MSB:ADDR_LSB] addr;
		l2cap_way_t way;
		l2cap_line_state_t state;
		logic [7:0] ecc;
		logic [63:0] data;
	} l2cap_req_t;
	typedef struct packed {
		logic hit;
		l2cap_line_state_t state;
		l2cap_way_t way;
		logic [7:0] ecc;
		logic [63:0] data;
	} l2cap_rsp_t;
	function automatic l2cap_op_t l2cap_decode(input logic [4:0] cmd);
		l2cap_op_t op;
		op = L2CAP_OP_NONE;
		case (cmd[4:2])
			PFX_TAG_WRITE_DATA_READ: op = L2CAP_OP_TAG_WRITE_DATA_READ;
			PFX_TAG_AND_DATA_WRITE: op = L2CAP_OP_TAG_AND_DATA_WRITE;
			PFX_TAG_WRITE_ONLY: op = L2CAP_OP_TAG_WRITE_ONLY;
			default: op = L2CAP_OP_NONE;
		endcase
		case (cmd)
			CMD_DATA_READ_LRU_TOUCH: op = L2CAP_OP_DATA_READ_LRU_TOUCH;
			CMD_TAG_AND_DATA_READ: op = L2CAP_OP_TAG_AND_DATA_READ;
			CMD_TAG_INQUIRE: op = L2CAP_OP_TAG_INQUIRE;
			CMD_CTRL_REG_READ: op = L2CAP_OP_CTRL_REG_READ;
			CMD_CTRL_REG_WRITE: op = L2CAP_OP_CTRL_REG_WRITE;
			default: op = op;
		endcase
		return op;
	endfunction
endpackage

// ---- hdl/l2cap_cmd_seq.sv ----
// Command sequencer: launch, busy and completion of one cache command
`timescale 1ns/1ps
module l2cap_cmd_seq (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic launch_i,
	input wire l2cap_pkg::l2cap_op_t op_i,
	input wire logic l2_done_i,
	output logic l2_req_o,
	output l2cap_pkg::l2cap_op_t op_o,
	output logic busy_o,
	output logic done_o
);
	typedef enum logic [2:0] {
		L2CAP_SQ_IDLE = 3'h1,
		L2CAP_SQ_RUN = 3'h2,
		L2CAP_SQ_FIN = 3'h4
	} l2cap_seq_t;
	l2cap_seq_t state;
	l2cap_seq_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			L2CAP_SQ_IDLE: begin
				if (launch_i) begin
					if (op_i == l2cap_pkg::L2CAP_OP_NONE) begin
						next_state = L2CAP_SQ_FIN;
					end else begin
						next_state = L2CAP_SQ_RUN;
					end
				end
			end
			L2CAP_SQ_RUN: begin
				if (l2_done_i) begin
					next_state = L2CAP_SQ_IDLE;
				end
			end
			L2CAP_SQ_FIN: next_state = L2CAP_SQ_IDLE;
			default: next_state = L2CAP_SQ_IDLE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= L2CAP_SQ_IDLE;
		end else if (ce_i) begin
			state <= next_state;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_o <= l2cap_pkg::L2CAP_OP_NONE;
		end else if (ce_i && state == L2CAP_SQ_IDLE && launch_i) begin
			op_o <= op_i;
		end
	end
	assign l2_req_o = (state == L2CAP_SQ_RUN);
	assign busy_o = (state != L2CAP_SQ_IDLE);
	assign done_o = ce_i && (state == L2CAP_SQ_RUN) && l2_done_i;
endmodule

// ---- tb/l2cap_props.sv ----
// Checker of command decode at the cache request port
`timescale 1ns/1ps
module l2cap_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic l2_req_valid_o,
	input wire l2cap_pkg::l2cap_req_t l2_req_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property dec_p(logic [4:0] c, logic [4:0] m, logic [8:0] o);
		l2_req_valid_o && (l2_req_o.cmd & m) == c |-> l2_req_o.op == o;
	endproperty
	lru_dec_a: assert property (dec_p(5'h0c, 5'h1f, 9'h002)) else $error("op");
	trr_dec_a: assert property (dec_p(5'h0e, 5'h1f, 9'h004)) else $error("op");
	inq_dec_a: assert property (dec_p(5'h0f, 5'h1f, 9'h008)) else $error("op");
	crd_dec_a: assert property (dec_p(5'h02, 5'h1f, 9'h010)) else $error("op");
	cwr_dec_a: assert property (dec_p(5'h03, 5'h1f, 9'h020)) else $error("op");
	twr_dec_a: assert property (dec_p(5'h08, 5'h1c, 9'h040)) else $error("op");
	tww_dec_a: assert property (dec_p(5'h1c, 5'h1c, 9'h080)) else $error("op");
	tw_dec_a: assert property (dec_p(5'h10, 5'h1c, 9'h100)) else $error("op");
endmodule
bind l2cap_top l2cap_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.l2_req_valid_o(l2_req_valid_o), .l2_req_o(l2_req_o));

// ---- tb/l2cap_l2_model.sv ----
// Behavioural cache answering each command after a delay
`timescale 1ns/1ps
module l2cap_l2_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	output logic done_o,
	output l2cap_pkg::l2cap_rsp_t rsp_o
);
	logic [3:0] cnt;
	logic was;
	l2cap_pkg::l2cap_rsp_t ans;
	assign ans = {1'b1, 2'h3, 2'h2, 8'h5a, 64'h0};
	assign rsp_o = done_o ? ans : ~ans;
	always_ff @(posedge clk_i) begin
		was <= req_valid_i;
		done_o <= !rst_i && cnt == 4'h1;
		if (rst_i) cnt <= 4'h0;
		else if (cnt != 4'h0) cnt <= cnt - 4'h1;
		else if (req_valid_i && !was) cnt <= 4'h8;
	end
endmodule

// ---- tb/l2cap_top_tb_top.sv ----
// Testbench of the cache command access port
`timescale 1ns/1ps
module l2cap_top_tb_top;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, valid, done, chk_en;
	logic [11:0] adr = 0;
	logic [31:0] wdat = 0, rdat, q;
	logic [2:0] range = 3'h5;
	logic hwdis = 1, frac = 1;
	l2cap_pkg::l2cap_req_t req;
	l2cap_pkg::l2cap_rsp_t rsp;
	int bad_count = 0, total_checks = 0, n = 0;
	logic [4:0] cmds [8] = '{5'h0c, 5'h0e, 5'h0f, 5'h02, 5'h03, 5'h0b, 5'h1e, 5'h11};
	l2cap_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_ack_o(ack), .l2_req_valid_o(valid), .l2_req_o(req),
		.l2_done_i(done), .l2_rsp_i(rsp), .cfg_addr_range_i(range),
		.cfg_hw_disable_i(hwdis), .cfg_bus_fraction_i(frac), .state_check_en_o(chk_en));
	l2cap_l2_model L2 (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(valid), .done_o(done),
		.rsp_o(rsp));
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		n++;
		if (n == 5000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d);
		adr <= {1'b0, a, 2'h0};
		wdat <= d;
		we <= w;
		cyc <= 1;
		@(posedge clk_i iff ack === 1'b1);
		q = rdat;
		cyc <= 0;
		@(posedge clk_i);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		acc(1, 9'h116, 32'h89abcde8);
		acc(0, 9'h116, 0);
		chk("addr", 32'h89abcde8, q);
		acc(1, 9'h08b, 32'h13572468);
		acc(0, 9'h08b, 0);
		chk("chunk3", 32'h13572468, q);
		acc(1, 9'h118, 32'ha5);
		acc(0, 9'h118, 0);
		chk("ecc", 32'ha5, q & 32'hff);
		foreach (cmds[i]) begin
			acc(1, 9'h119, {22'h0, 2'h1, 1'b0, 2'h2, cmds[i]});
			acc(1, 9'h11a, 0);
			acc(0, 9'h11b, 0);
			chk("busy", 1, q & 1);
			do acc(0, 9'h11b, 0); while (q[0] !== 1'b0);
			acc(0, 9'h119, 0);
			chk("cmd", {27'h0, cmds[i]}, q & 32'h1f);
			chk("outgoing", 32'h140, q & 32'h360);
			if (i == 2) chk("resp", 32'h2c800, q & 32'h2cc00);
			if (i == 1) acc(0, 9'h118, 0);
			if (i == 1) chk("ecc in", 32'h5a, q & 32'hff);
		end
		acc(0, 9'h11e, 0);
		chk("cfg", 32'h2d00000, q & 32'h2f00000);
		acc(1, 9'h11e, 32'h40000);
		acc(0, 9'h11e, 0);
		chk("cfg", 32'h2d40000, q & 32'h2f40000);
		chk("chk_en", 1, {31'h0, chk_en});
		acc(0, 9'h0f0, 0);
		chk("unmapped", 0, q);
		finish_test();
	end
endmodule
